// ==== inc/pic_consts.vh ====
// constants for the parallel issue checker: bundle layout, slot encodings, states
`ifndef PIC_CONSTS_VH
`define PIC_CONSTS_VH

// bundle layout: wide slot on top, then first and second narrow slots
`define PIC_BUNDLE_W 64
`define PIC_WIDE_HI 63
`define PIC_WIDE_LO 32
`define PIC_S1_HI 31
`define PIC_S1_LO 16
`define PIC_S2_HI 15
`define PIC_S2_LO 0

// wide slot fields
`define PIC_W_CLS_HI 31
`define PIC_W_CLS_LO 26
`define PIC_W_FORM_HI 25
`define PIC_W_FORM_LO 24

// wide slot classes
`define PIC_W_MNOP 6'h00
`define PIC_W_ADD 6'h01
`define PIC_W_SUB 6'h02
`define PIC_W_MOVE 6'h03
`define PIC_W_ASHIFT 6'h04
`define PIC_W_LSHIFT 6'h05
`define PIC_W_MAC_ACC 6'h06
`define PIC_W_MAC_HALF 6'h07
`define PIC_W_MAC_DREG 6'h08
`define PIC_W_DEPOSIT 6'h09
`define PIC_W_EXTRACT 6'h0a
`define PIC_W_BITMUX 6'h0b
`define PIC_W_ONES 6'h0c
`define PIC_W_ALIGN 6'h0d
`define PIC_W_NOMISALIGN 6'h0e
`define PIC_W_SAA 6'h0f
`define PIC_W_QADD 6'h10
`define PIC_W_QSUB 6'h11
`define PIC_W_QAVG 6'h12
`define PIC_W_QPACK 6'h13
`define PIC_W_QUNPACK 6'h14
`define PIC_W_SEARCH 6'h15
`define PIC_W_OTHER 6'h16

// wide form bits
`define PIC_F_SAT 0
`define PIC_F_ACC 1
`define PIC_F_WIDE32 1

// narrow slot fields
`define PIC_N_CLS_HI 15
`define PIC_N_CLS_LO 12
`define PIC_N_IDX 11
`define PIC_N_MODE_HI 10
`define PIC_N_MODE_LO 9
`define PIC_N_DST_HI 8
`define PIC_N_DST_LO 6
`define PIC_N_ADR_HI 5
`define PIC_N_ADR_LO 3

// narrow slot classes
`define PIC_N_NOP 4'h0
`define PIC_N_IARITH 4'h1
`define PIC_N_LD_PTR 4'h2
`define PIC_N_LD_DATA 4'h3
`define PIC_N_LD_HALFZ 4'h4
`define PIC_N_LD_HALFS 4'h5
`define PIC_N_LD_HI 4'h6
`define PIC_N_LD_LO 4'h7
`define PIC_N_LD_BYTEZ 4'h8
`define PIC_N_LD_BYTES 4'h9
`define PIC_N_ST_PTR 4'ha
`define PIC_N_ST_DATA 4'hb
`define PIC_N_ST_HI 4'hc
`define PIC_N_ST_LO 4'hd
`define PIC_N_ST_BYTE 4'he

// address modes
`define PIC_AM_PLAIN 2'h0
`define PIC_AM_POSTINC 2'h1
`define PIC_AM_POSTMOD 2'h2

// implied array pointer register number
`define PIC_ARRAY_PTR 3'h0

// controller states
`define PIC_ST_IDLE 2'h0
`define PIC_ST_WAIT 2'h1
`define PIC_ST_REJECT 2'h2

`endif

// ==== src/pic_parallel_issue_checker.v ====
// parallel issue checker: splits, checks and issues 64-bit multi-issue bundles
`timescale 1ns/1ps
`default_nettype none
`include "pic_consts.vh"
// Overview of operation
// [RULE1] a bundle is taken and checked as one 64-bit word
// [RULE2] split into one 32-bit wide slot then two 16-bit slots, each decoded alone
// [RULE3] at most three instructions issue from one bundle
// [RULE4] bundle finishes only when every issued slot has finished
// [RULE5] unused narrow slot holds a 16-bit no-op and is decoded as such
// [RULE6] wide no-op slot means only the two narrow slots execute
// [RULE7] first narrow slot from first class, second from second class
// [RULE8] first class: index arithmetic, pointer/data/half/byte loads and stores
// [RULE9] second class: index-addressed data or half loads and stores, or no-op
// [RULE10] at most one narrow slot may be a store
// [RULE11] two memory accesses may not both address through pointer registers
// [RULE12] search pairs only with one array-pointer load and one no-op
// [RULE13] load beside search: plain or post-increment, never post-modify
// [RULE14] wide add or subtract only in saturating form
// [RULE15] wide register move only in accumulator form
// [RULE16] wide arithmetic shift only saturating or accumulator form
// [RULE17] wide logical shift only in 32-bit form
// [RULE18] all multiply and multiply-accumulate destinations accepted
// [RULE19] deposit, extract, bit multiplex and ones count accepted
// [RULE20] video pixel operations accepted in the wide slot
// [RULE21] any broken restriction flags the bundle illegal instead of executing
module pic_parallel_issue_checker (
  input wire sys_clk,
  input wire sys_rst,
  input wire bundleValid,
  input wire [63:0] bundleWord,
  input wire wideDone,
  input wire firstDone,
  input wire secondDone,
  output reg bundleReady,
  output reg issueWide,
  output reg issueFirst,
  output reg issueSecond,
  output reg [31:0] wideWord,
  output reg [15:0] firstWord,
  output reg [15:0] secondWord,
  output reg [1:0] issueCount,
  output reg illegalBundle,
  output reg bundleDone
);

  // narrow class helpers, applied to both narrow slots
  function isLoad;
    input [15:0] w;
    reg [3:0] c;
    begin
      c = w[`PIC_N_CLS_HI:`PIC_N_CLS_LO];
      isLoad = (c >= `PIC_N_LD_PTR) && (c <= `PIC_N_LD_BYTES);
    end
  endfunction

  function isStore;
    input [15:0] w;
    reg [3:0] c;
    begin
      c = w[`PIC_N_CLS_HI:`PIC_N_CLS_LO];
      isStore = (c >= `PIC_N_ST_PTR) && (c <= `PIC_N_ST_BYTE);
    end
  endfunction

  function isNop;
    input [15:0] w;
    begin
      isNop = (w[`PIC_N_CLS_HI:`PIC_N_CLS_LO] == `PIC_N_NOP);
    end
  endfunction

  // memory access through a pointer register rather than an index register
  function ptrAccess;
    input [15:0] w;
    begin
      ptrAccess = (isLoad(w) || isStore(w)) && !w[`PIC_N_IDX];
    end
  endfunction

  // first class accepts every defined narrow code, index arithmetic only with the index bit set
  function firstClassOk;
    input [15:0] w;
    reg [3:0] c;
    begin
      c = w[`PIC_N_CLS_HI:`PIC_N_CLS_LO];
      firstClassOk = (c == `PIC_N_NOP) || (c == `PIC_N_IARITH && w[`PIC_N_IDX]) ||
        isLoad(w) || isStore(w);
    end
  endfunction

  // second class: index forms of full and half data transfers, or no-op
  function secondClassOk;
    input [15:0] w;
    reg [3:0] c;
    begin
      c = w[`PIC_N_CLS_HI:`PIC_N_CLS_LO];
      case (c)
        `PIC_N_NOP: secondClassOk = 1'b1;
        `PIC_N_LD_DATA, `PIC_N_LD_HI, `PIC_N_LD_LO,
        `PIC_N_ST_DATA, `PIC_N_ST_HI, `PIC_N_ST_LO: secondClassOk = w[`PIC_N_IDX];
        default: secondClassOk = 1'b0;
      endcase
    end
  endfunction

  // wide slot class and form check
  function wideOk;
    input [31:0] w;
    reg [5:0] c;
    reg [1:0] f;
    begin
      c = w[`PIC_W_CLS_HI:`PIC_W_CLS_LO];
      f = w[`PIC_W_FORM_HI:`PIC_W_FORM_LO];
      case (c)
        `PIC_W_MNOP: wideOk = 1'b1;
        `PIC_W_ADD, `PIC_W_SUB: wideOk = f[`PIC_F_SAT]; // see [RULE14]
        `PIC_W_MOVE: wideOk = f[`PIC_F_ACC]; // see [RULE15]
        `PIC_W_ASHIFT: wideOk = f[`PIC_F_SAT] | f[`PIC_F_ACC]; // see [RULE16]
        `PIC_W_LSHIFT: wideOk = f[`PIC_F_WIDE32]; // see [RULE17]
        `PIC_W_MAC_ACC, `PIC_W_MAC_HALF, `PIC_W_MAC_DREG: wideOk = 1'b1; // see [RULE18]
        `PIC_W_DEPOSIT, `PIC_W_EXTRACT, `PIC_W_BITMUX, `PIC_W_ONES: wideOk = 1'b1; // see [RULE19]
        `PIC_W_ALIGN, `PIC_W_NOMISALIGN, `PIC_W_SAA, `PIC_W_QADD, `PIC_W_QSUB,
        `PIC_W_QAVG, `PIC_W_QPACK, `PIC_W_QUNPACK: wideOk = 1'b1; // see [RULE20]
        `PIC_W_SEARCH, `PIC_W_OTHER: wideOk = 1'b1;
        default: wideOk = 1'b0;
      endcase
    end
  endfunction

  reg [1:0] state;
  reg [2:0] pending;

  // slot split of the incoming word, whole word taken at once
  wire [31:0] inWide = bundleWord[`PIC_WIDE_HI:`PIC_WIDE_LO]; // see [RULE1] see [RULE2]
  wire [15:0] inFirst = bundleWord[`PIC_S1_HI:`PIC_S1_LO];
  wire [15:0] inSecond = bundleWord[`PIC_S2_HI:`PIC_S2_LO];
  wire wideIsNop = (inWide[`PIC_W_CLS_HI:`PIC_W_CLS_LO] == `PIC_W_MNOP); // see [RULE6]
  wire firstIsNop = isNop(inFirst);
  wire secondIsNop = isNop(inSecond); // see [RULE5]
  wire wideIsSearch = (inWide[`PIC_W_CLS_HI:`PIC_W_CLS_LO] == `PIC_W_SEARCH);

  // per-slot and cross-slot checks
  wire classFail = !firstClassOk(inFirst) || !secondClassOk(inSecond); // see [RULE7] see [RULE8] see [RULE9]
  wire storeFail = isStore(inFirst) && isStore(inSecond); // see [RULE10]
  wire ptrFail = ptrAccess(inFirst) && ptrAccess(inSecond); // see [RULE11]
  wire [1:0] firstMode = inFirst[`PIC_N_MODE_HI:`PIC_N_MODE_LO];
  // search partner must be a pointer-addressed load on the array pointer
  wire searchLoadOk = isLoad(inFirst) && !inFirst[`PIC_N_IDX] &&
    (inFirst[`PIC_N_ADR_HI:`PIC_N_ADR_LO] == `PIC_ARRAY_PTR) &&
    ((firstMode == `PIC_AM_PLAIN) || (firstMode == `PIC_AM_POSTINC)); // see [RULE13]
  wire searchFail = wideIsSearch && !(searchLoadOk && secondIsNop); // see [RULE12]
  wire bundleBad = !wideOk(inWide) || classFail || storeFail || ptrFail || searchFail;

  // active slots; no-op slots are never handed to a unit
  wire [2:0] active = {!wideIsNop, !firstIsNop, !secondIsNop};
  // count cannot exceed three since there are only three slots
  wire [1:0] activeCount = {1'b0, active[2]} + {1'b0, active[1]} + {1'b0, active[0]}; // see [RULE3]

  wire accept = bundleValid && bundleReady && (state == `PIC_ST_IDLE);
  wire [2:0] doneNow = {wideDone, firstDone, secondDone};
  wire [2:0] remaining = pending & ~doneNow;

  // controller: accept, then issue and hold until all issued slots report done, or reject
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= `PIC_ST_IDLE;
      pending <= 3'h0;
      bundleReady <= 1'b1;
      issueWide <= 1'b0;
      issueFirst <= 1'b0;
      issueSecond <= 1'b0;
      wideWord <= 32'h0000_0000;
      firstWord <= 16'h0000;
      secondWord <= 16'h0000;
      issueCount <= 2'h0;
      illegalBundle <= 1'b0;
      bundleDone <= 1'b0;
    end else begin
      issueWide <= 1'b0;
      issueFirst <= 1'b0;
      issueSecond <= 1'b0;
      illegalBundle <= 1'b0;
      bundleDone <= 1'b0;
      case (state)
        `PIC_ST_IDLE: begin
          if (accept) begin
            bundleReady <= 1'b0;
            wideWord <= inWide;
            firstWord <= inFirst;
            secondWord <= inSecond;
            if (bundleBad) begin
              // nothing reaches the units from a rejected bundle
              illegalBundle <= 1'b1; // see [RULE21]
              issueCount <= 2'h0;
              state <= `PIC_ST_REJECT;
            end else begin
              issueWide <= active[2];
              issueFirst <= active[1];
              issueSecond <= active[0];
              issueCount <= activeCount;
              pending <= active;
              state <= `PIC_ST_WAIT;
            end
          end
        end
        `PIC_ST_WAIT: begin
          // slowest member sets the bundle time; done strobes in the accept cycle ignored
          pending <= remaining; // see [RULE4]
          if (remaining == 3'h0) begin
            bundleDone <= 1'b1;
            bundleReady <= 1'b1;
            state <= `PIC_ST_IDLE;
          end
        end
        `PIC_ST_REJECT: begin
          bundleReady <= 1'b1;
          state <= `PIC_ST_IDLE;
        end
        default: begin
          bundleReady <= 1'b1;
          pending <= 3'h0;
          state <= `PIC_ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== bench/pic_monitor.sv ====
// port checker for the parallel issue checker
`timescale 1ns/1ps
`default_nettype none
module pic_monitor (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic bundleValid,
  input wire logic [63:0] bundleWord,
  input wire logic wideDone,
  input wire logic firstDone,
  input wire logic secondDone,
  input wire logic bundleReady,
  input wire logic issueWide,
  input wire logic issueFirst,
  input wire logic issueSecond,
  input wire logic [31:0] wideWord,
  input wire logic [15:0] firstWord,
  input wire logic [15:0] secondWord,
  input wire logic [1:0] issueCount,
  input wire logic illegalBundle,
  input wire logic bundleDone
);
  wire logic [2:0] iss = {issueSecond, issueFirst, issueWide};
  wire logic [3:0] c1 = bundleWord[31:28];
  wire logic [3:0] c2 = bundleWord[15:12];
  logic [2:0] pend;
  // slots still owed a done, so completion is judged without the body
  always @(posedge sys_clk) begin
    if (sys_rst) pend <= 3'h0;
    else pend <= (pend | iss) & ~{secondDone, firstDone, wideDone};
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence sTake; bundleValid && bundleReady; endsequence
  sequence sIssued; sTake ##1 (iss != 3'h0); endsequence
  a_ready_drop: assert property (sTake |=> !bundleReady) else $error("ready held");
  a_slot_split: assert property (sTake |=>
    {wideWord, firstWord, secondWord} == $past(bundleWord)) else $error("bad split");
  a_issue_count: assert property (sIssued |->
    issueCount == iss[0] + iss[1] + iss[2]) else $error("bad count");
  a_done_wait: assert property (bundleDone |-> pend == 3'h0) else $error("early");
  a_done_prompt: assert property (pend != 3'h0 ##1 pend == 3'h0 |-> bundleDone)
    else $error("late done");
  a_nop_slot: assert property ((sTake and c2 == 4'h0) |=> !issueSecond)
    else $error("nop issued");
  a_mnop_wide: assert property ((sTake and bundleWord[63:58] == 6'h00) |=> !issueWide)
    else $error("mnop issued");
  a_two_stores: assert property ((sTake and (c1 > 4'h9 && c1 < 4'hf && c2 > 4'h9 &&
    c2 < 4'hf)) |=> illegalBundle) else $error("two stores");
  a_ptr_pair: assert property ((sTake and (c1 > 4'h1 && c1 < 4'hf && c2 > 4'h1 &&
    c2 < 4'hf && !bundleWord[27] && !bundleWord[11])) |=> illegalBundle) else $error("two ptrs");
  a_search_mode: assert property ((sTake and (bundleWord[63:58] == 6'h15 &&
    bundleWord[26:25] == 2'h2)) |=> illegalBundle) else $error("postmod taken");
  a_reject_clean: assert property (illegalBundle |->
    iss == 3'h0 && issueCount == 2'h0 ##1 bundleReady) else $error("reject leaked");
endmodule
`default_nettype wire

// ==== bench/pic_exec_units.sv ====
// behavioural execution units answering issued slots after a set latency
`timescale 1ns/1ps
`default_nettype none
module pic_exec_units (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [2:0] issue,
  input wire logic [11:0] lat,
  output logic [2:0] done
);
  logic [3:0] cnt [3];
  // count down per unit; a done never lands in the issue cycle itself
  always @(negedge sys_clk) begin
    for (int i = 0; i < 3; i++) begin
      done[i] <= 1'b0;
      if (sys_rst) cnt[i] <= 4'h0;
      else if (issue[i]) cnt[i] <= lat[4*i+:4];
      else if (cnt[i] != 4'h0) begin
        cnt[i] <= cnt[i] - 4'h1;
        done[i] <= (cnt[i] == 4'h1);
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/pic_parallel_issue_checker_tb.sv ====
// self-checking bench for the parallel issue checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: got %h", $time, a); end end
module pic_parallel_issue_checker_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic bundleValid = 1'b0;
  logic [63:0] bundleWord = 64'h0;
  logic [11:0] lat = 12'h111;
  wire logic [2:0] iss, done;
  wire logic bundleReady, bundleDone, illegalBundle;
  wire logic [31:0] wideWord;
  wire logic [15:0] firstWord, secondWord;
  wire logic [1:0] issueCount;
  int fails = 0;
  int testsRun = 0;
  always #20 sys_clk = ~sys_clk;
  pic_parallel_issue_checker pic_parallel_issue_checker_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bundleValid(bundleValid), .bundleWord(bundleWord), .wideDone(done[0]),
    .firstDone(done[1]), .secondDone(done[2]), .bundleReady(bundleReady),
    .issueWide(iss[0]), .issueFirst(iss[1]), .issueSecond(iss[2]), .wideWord(wideWord),
    .firstWord(firstWord), .secondWord(secondWord), .issueCount(issueCount),
    .illegalBundle(illegalBundle), .bundleDone(bundleDone));
  pic_exec_units pic_exec_units_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .issue(iss),
    .lat(lat), .done(done));
  // narrow slot: class, index addressing, mode, address register
  function automatic [15:0] nw(input [3:0] c, input x, input [1:0] m, input [2:0] a);
    nw = {c, x, m, 3'h1, a, 3'h0};
  endfunction
  // offer one bundle at a falling edge, judge the answer, wait for completion
  task automatic send(input [63:0] b, input ill, input [1:0] cnt);
    int n;
    n = 0;
    while (!bundleReady && n < 50) begin @(negedge sys_clk); n++; end
    bundleValid = 1'b1;
    bundleWord = b;
    @(negedge sys_clk);
    bundleValid = 1'b0;
    `CHK(illegalBundle, ill)
    `CHK(issueCount, ill ? 2'h0 : cnt)
    `CHK(iss, ill ? 3'h0 : {b[15:12] != 0, b[31:28] != 0, b[63:58] != 0})
    `CHK({wideWord, firstWord, secondWord}, b)
    n = 0;
    while (!ill && !bundleDone && n < 50) begin @(negedge sys_clk); n++; end
    `CHK(bundleDone | ill, 1'b1)
  endtask
  // three units at different speeds, then back to back with a nop slot
  task automatic tFull;
    lat = 12'h925;
    send({6'h06, 26'h0, nw(4'h2, 1'b0, 2'h1, 3'h2), nw(4'hb, 1'b1, 2'h0, 3'h1)}, 1'b0, 2'h3);
    send({6'h10, 26'h0, nw(4'h1, 1'b1, 2'h2, 3'h1), 16'h0}, 1'b0, 2'h2);
    $display("test full done");
  endtask
  // wide no-op slot, then a bundle of no-ops only
  task automatic tMnop;
    lat = 12'h131;
    send({32'h0, nw(4'ha, 1'b0, 2'h0, 3'h4), nw(4'h7, 1'b1, 2'h1, 3'h2)}, 1'b0, 2'h2);
    send(64'h0, 1'b0, 2'h0);
    $display("test mnop done");
  endtask
  // class, store and address register breaches are all rejected
  task automatic tSlots;
    logic [31:0] bad [5];
    bad = '{{nw(4'h3, 1'b0, 2'h0, 3'h0), nw(4'h2, 1'b1, 2'h0, 3'h0)},
      {nw(4'h3, 1'b0, 2'h0, 3'h0), nw(4'h3, 1'b0, 2'h0, 3'h1)},
      {nw(4'hf, 1'b1, 2'h0, 3'h0), 16'h0}, {nw(4'h1, 1'b0, 2'h0, 3'h0), 16'h0},
      {nw(4'hb, 1'b1, 2'h0, 3'h1), nw(4'hc, 1'b1, 2'h1, 3'h2)}};
    foreach (bad[i]) send({6'h08, 26'h0, bad[i]}, 1'b1, 2'h0);
    $display("test slots done");
  endtask
  // search pairs only with a plain or post-increment load via the array pointer
  task automatic tSearch;
    send({6'h15, 26'h0, nw(4'h3, 1'b0, 2'h1, 3'h0), 16'h0}, 1'b0, 2'h2);
    send({6'h15, 26'h0, nw(4'h3, 1'b0, 2'h2, 3'h0), 16'h0}, 1'b1, 2'h0);
    send({6'h15, 26'h0, nw(4'h3, 1'b0, 2'h0, 3'h3), 16'h0}, 1'b1, 2'h0);
    send({6'h15, 26'h0, nw(4'h3, 1'b0, 2'h0, 3'h0), nw(4'h3, 1'b1, 2'h0, 3'h1)}, 1'b1, 2'h0);
    $display("test search done");
  endtask
  // wide classes 1 to 23 in every form; class 23, past the last allowed one, is refused
  task automatic tWide;
    logic ok;
    for (int c = 1; c < 24; c++) begin
      for (int f = 0; f < 4; f++) begin
        ok = (c < 3) ? f[0] : (c == 3 || c == 5) ? f[1] : (c == 4) ? (f != 0) : (c < 23);
        send({c[5:0], f[1:0], 24'h0, nw(4'h3, 1'b0, 2'h0, 3'h0), 16'h0}, !ok, 2'h2);
      end
    end
    $display("test wide done");
  endtask
  // print the counts and the verdict, then stop
  task automatic tallyAndFinish;
    $display("comparisons %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge sys_clk);
    sys_rst = 1'b0;
    tFull();
    tMnop();
    tSlots();
    tSearch();
    tWide();
    tallyAndFinish();
  end
  // watchdog well past the 105 bundles above
  initial begin
    #(40 * 20000);
    fails++;
    tallyAndFinish();
  end
endmodule
bind pic_parallel_issue_checker pic_monitor pic_monitor_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .bundleValid(bundleValid), .bundleWord(bundleWord), .wideDone(wideDone),
  .firstDone(firstDone), .secondDone(secondDone), .bundleReady(bundleReady),
  .issueWide(issueWide), .issueFirst(issueFirst), .issueSecond(issueSecond),
  .wideWord(wideWord), .firstWord(firstWord), .secondWord(secondWord),
  .issueCount(issueCount), .illegalBundle(illegalBundle), .bundleDone(bundleDone));
`default_nettype wire
